// ===== design/spi_cfg_status.sv
// Serial port unit: configuration and status register with its shifter.
// Assumes register port, data port and enable come from the CPU clock
// domain; serial pins are asynchronous and are synchronised here.
`timescale 1ns/1ps
`default_nettype none
module spi_cfg_status (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic spi_enable,
   input wire logic tx_wr,
   input wire logic [7:0] tx_data,
   output logic tx_buffer_empty,
   input wire logic rx_rd,
   output logic [7:0] rx_data,
   output logic transfer_complete_flag,
   input wire logic slave_select_n,
   input wire logic sck_i,
   output logic sck_o,
   output logic sck_oe,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe
);
   import spi_cfg_pkg::*;

   logic master_q;
   logic phase_q;
   logic pol_q;
   logic [7:0] rdata_q;
   logic [7:0] sr_q;
   logic [7:0] txb_q;
   logic txbmt_q;
   logic sr_loaded_q;
   logic shift_register_empty_q;
   logic [7:0] rxb_q;
   logic receive_buffer_empty_q;
   logic out_q;
   logic done_q;
   logic run_q;
   logic [3:0] half_q;
   logic [3:0] cyc_q;
   logic [2:0] cnt_q;
   logic sck_prev_q;
   logic ss_prev_q;
   logic ss_lvl;
   logic ss_filt;
   logic sck_s;
   logic mosi_s;
   logic miso_s;

   sync_deglitch #(.INIT(1'b1)) u_ss (
      .clock(clock), .rst_n(rst_n), .pin(slave_select_n),
      .level(ss_lvl), .filtered(ss_filt));
   sync_deglitch #(.INIT(1'b0)) u_sck (
      .clock(clock), .rst_n(rst_n), .pin(sck_i),
      .level(sck_s), .filtered());
   sync_deglitch #(.INIT(1'b0)) u_mosi (
      .clock(clock), .rst_n(rst_n), .pin(mosi_i),
      .level(mosi_s), .filtered());
   sync_deglitch #(.INIT(1'b0)) u_miso (
      .clock(clock), .rst_n(rst_n), .pin(miso_i),
      .level(miso_s), .filtered());

   // Register port decode
   wire cfg_hit = (sfr_addr == CFG_ADDR);
   wire cfg_wr = sfr_wr & cfg_hit;
   wire cfg_rd = sfr_rd & cfg_hit;

   // Role selection
   wire is_master = spi_enable & master_q;
   wire slave_act = spi_enable & ~master_q & ~ss_filt;

   // Slave clock edge detection on the synchronised clock
   wire sck_edge = slave_act & (sck_s != sck_prev_q);
   wire lead = sck_edge & (sck_s != pol_q);
   wire trail = sck_edge & (sck_s == pol_q);
   wire s_samp = phase_q ? trail : lead;
   wire s_shift = phase_q ? lead : trail;
   wire ss_fall = ss_prev_q & ~ss_filt;

   // Master timing
   wire half_end = run_q & (cyc_q == SCK_LAST_CYC);
   wire m_samp = half_end & half_q[0];
   wire m_done = m_samp & (half_q == LAST_HALF);
   wire s_done = s_samp & (cnt_q == LAST_BIT);
   wire complete = m_done | s_done;
   wire samp = m_samp | s_samp;
   wire samp_bit = is_master ? miso_s : mosi_s;
   wire busy = run_q | (slave_act & (cnt_q != 3'h0));

   // Transmit path
   wire tx_take = tx_wr & txbmt_q;
   wire load_now = ~txbmt_q & ~sr_loaded_q & ~busy;
   wire start = is_master & sr_loaded_q & ~run_q & ~load_now;
   wire rx_take = complete & (receive_buffer_empty_q | rx_rd);

   // A byte ends on its last clock edge, in phase 0 the trailing one
   wire s_last = phase_q ? s_done : (s_shift & (cnt_q == 3'h0));
   wire shift_register_empty_set = s_last & txbmt_q & (phase_q | ~sr_loaded_q);

   // Status read value
   wire shift_register_empty_rd = is_master | master_q | shift_register_empty_q;
   wire receive_buffer_empty_rd = master_q | receive_buffer_empty_q;
   wire [7:0] cfg_value = {busy, master_q, phase_q, pol_q,
      ~ss_filt, ss_lvl, shift_register_empty_rd, receive_buffer_empty_rd};

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         master_q <= CFG_RESET[BIT_MASTER];
         phase_q <= CFG_RESET[BIT_PHASE];
         pol_q <= CFG_RESET[BIT_POLARITY];
         rdata_q <= 8'h00;
      end else begin
         if (cfg_wr) begin
            master_q <= sfr_wdata[BIT_MASTER];
            phase_q <= sfr_wdata[BIT_PHASE];
            pol_q <= sfr_wdata[BIT_POLARITY];
         end
         rdata_q <= cfg_rd ? cfg_value : 8'h00;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         txb_q <= 8'h00;
         txbmt_q <= 1'b1;
      end else if (tx_take) begin
         txb_q <= tx_data;
         txbmt_q <= 1'b0;
      end else if (load_now) begin
         txbmt_q <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sr_q <= 8'h00;
         sr_loaded_q <= 1'b0;
         out_q <= 1'b0;
      end else if (load_now) begin
         sr_q <= txb_q;
         sr_loaded_q <= 1'b1;
         out_q <= txb_q[7];
      end else begin
         if (samp) begin
            sr_q <= {sr_q[6:0], samp_bit};
         end
         if (m_samp) begin
            out_q <= sr_q[6];
         end else if (s_shift | ss_fall) begin
            out_q <= sr_q[7];
         end
         if (complete) begin
            sr_loaded_q <= 1'b0;
         end
      end
   end

   // Shift register empty: the last edge of a byte sets it if the transmit buffer is empty, later edges clear
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         shift_register_empty_q <= CFG_RESET[BIT_SR_EMPTY];
      end else if (shift_register_empty_set) begin
         shift_register_empty_q <= 1'b1;
      end else if (load_now | sck_edge) begin
         shift_register_empty_q <= 1'b0;
      end
   end

   // Receive buffer; a new byte wins over a read in the same cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rxb_q <= 8'h00;
         receive_buffer_empty_q <= CFG_RESET[BIT_RX_EMPTY];
      end else if (rx_take) begin
         rxb_q <= {sr_q[6:0], samp_bit};
         receive_buffer_empty_q <= 1'b0;
      end else if (rx_rd) begin
         receive_buffer_empty_q <= 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         run_q <= 1'b0;
         half_q <= 4'h0;
         cyc_q <= 4'h0;
      end else if (start) begin
         run_q <= 1'b1;
         half_q <= 4'h0;
         cyc_q <= 4'h0;
      end else if (m_done | ~is_master) begin
         run_q <= 1'b0;
      end else if (half_end) begin
         half_q <= half_q + 4'h1;
         cyc_q <= 4'h0;
      end else if (run_q) begin
         cyc_q <= cyc_q + 4'h1;
      end
   end

   // Slave bit counter
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt_q <= 3'h0;
         sck_prev_q <= 1'b0;
         ss_prev_q <= 1'b1;
         done_q <= 1'b0;
      end else begin
         sck_prev_q <= sck_s;
         ss_prev_q <= ss_filt;
         done_q <= complete;
         if (ss_fall | ~spi_enable | master_q) begin
            cnt_q <= 3'h0;
         end else if (s_samp) begin
            cnt_q <= cnt_q + 3'h1;
         end
      end
   end

   // Clock idles at polarity, toggles per half period when running
   wire sck_active = phase_q ? ~half_q[0] : half_q[0];
   assign sck_o = run_q ? (pol_q ^ sck_active) : pol_q;
   assign sck_oe = is_master;
   assign mosi_o = out_q;
   assign mosi_oe = is_master;
   assign miso_o = out_q;
   assign miso_oe = slave_act;
   assign sfr_rdata = rdata_q;
   assign rx_data = rxb_q;
   assign tx_buffer_empty = txbmt_q;
   assign transfer_complete_flag = done_q;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // Protocol checks
   AST_BUSY_HOLD: assert property ($rose(run_q) |-> run_q[*8])
      else $error("Busy dropped early in master transfer");
   AST_BUSY_SLAVE: assert property (s_samp && cnt_q != LAST_BIT
      |=> busy)
      else $error("Busy dropped inside a slave byte");
   AST_MASTER_OE: assert property (is_master
      |-> sck_oe && mosi_oe && !miso_oe)
      else $error("Master role drives the wrong pins");
   AST_SCK_IDLE: assert property (!run_q |-> sck_o == pol_q)
      else $error("Serial clock not at idle polarity");
   AST_PHASE_FIRST: assert property (run_q && half_q == 4'h0
      && !phase_q |-> sck_o == pol_q)
      else $error("Phase 0 clock left idle too early");
   AST_SLV_SEL: assert property (cfg_rd
      |=> rdata_q[3] == !$past(ss_filt))
      else $error("Slave-selected bit does not follow filtered select");
   AST_RAW_SEL: assert property (cfg_rd
      |=> rdata_q[2] == $past(ss_lvl))
      else $error("Raw select bit does not follow the pin");
   AST_SHIFT_REGISTER_EMPTY_MASTER: assert property (master_q |-> cfg_value[1])
      else $error("Shift empty not 1 in master role");
   AST_RECEIVE_BUFFER_EMPTY_MASTER: assert property (master_q |-> cfg_value[0])
      else $error("Receive empty not 1 in master role");
   AST_SHIFT_REGISTER_EMPTY_CLEAR: assert property (sck_edge && !shift_register_empty_set
      |=> !shift_register_empty_q)
      else $error("Shift empty not cleared by clock edge");
   AST_RX_FULL: assert property (complete && receive_buffer_empty_q
      |=> !receive_buffer_empty_q && transfer_complete_flag)
      else $error("Completed byte not placed in receive buffer");
   AST_RX_READ: assert property (rx_rd && !complete |=> receive_buffer_empty_q)
      else $error("Receive empty not set after read");
   AST_RX_KEEP: assert property (complete && !receive_buffer_empty_q && !rx_rd
      |=> $stable(rx_data))
      else $error("Unread receive byte overwritten");
   AST_SS_CLEAR: assert property (ss_fall |=> cnt_q == 3'h0)
      else $error("Bit counter not cleared on select fall");
   AST_MASTER_SAMPLE: assert property (m_samp && !m_done
      |=> sck_o != $past(sck_o))
      else $error("Master sample not in last cycle of the bit");
   AST_SS_FILTER: assert property (!$stable(ss_filt)
      |-> ss_filt == $past(ss_lvl) && ss_filt == $past(ss_lvl, 2))
      else $error("Filtered select moved without two stable samples");
endmodule // spi_cfg_status
`default_nettype wire

// ===== design/spi_cfg_pkg.sv
// Constants for the serial port configuration and status register.
// Assumes a 10 MHz system clock and an 8-bit special function register port.
package spi_cfg_pkg;
   localparam logic [7:0] CFG_ADDR = 8'ha1;
   localparam logic [7:0] CFG_RESET = 8'h07;
   localparam int BIT_BUSY = 7;
   localparam int BIT_MASTER = 6;
   localparam int BIT_PHASE = 5;
   localparam int BIT_POLARITY = 4;
   localparam int BIT_SLV_SEL = 3;
   localparam int BIT_SS_RAW = 2;
   localparam int BIT_SR_EMPTY = 1;
   localparam int BIT_RX_EMPTY = 0;
   localparam int CLK_PERIOD_NS = 100;
   localparam int SCK_HALF_NS = 200;
   // Least time, so rounded up, never below one cycle
   localparam int SCK_HALF_CLKS_RAW =
      (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SCK_HALF_CLKS = (SCK_HALF_CLKS_RAW < 1) ? 1 :
      SCK_HALF_CLKS_RAW;
   localparam logic [3:0] SCK_LAST_CYC = 4'(SCK_HALF_CLKS - 1);
   localparam logic [3:0] LAST_HALF = 4'hf;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam int SS_SETUP_CLKS = 2;
endpackage : spi_cfg_pkg

// ===== design/sync_deglitch.sv
// Two-flop synchroniser with a two-sample stability filter.
// Assumes the input is asynchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module sync_deglitch #(
   parameter logic INIT = 1'b0
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic pin,
   output logic level,
   output logic filtered
);
   logic meta_q;
   logic sync_q;
   logic prev_q;
   logic filt_q;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         meta_q <= INIT;
         sync_q <= INIT;
         prev_q <= INIT;
         filt_q <= INIT;
      end else begin
         meta_q <= pin;
         sync_q <= meta_q;
         prev_q <= sync_q;
         // Update only after two equal consecutive samples
         if (sync_q == prev_q) begin
            filt_q <= prev_q;
         end
      end
   end

   assign level = sync_q;
   assign filtered = filt_q;
endmodule // sync_deglitch
`default_nettype wire

// ===== test/spi_far_end.sv
// Far-side model: serial master for slave role, serial slave for master role.
// Assumes the bench calls its tasks and sets the mode inputs.
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
   input wire logic cpol,
   input wire logic cpha,
   input wire logic sck_o,
   input wire logic sck_oe,
   input wire logic mosi_o,
   input wire logic miso_o,
   output var logic slave_select_n,
   output var logic sck_i,
   output var logic mosi_i,
   output var logic miso_i
);
   logic [7:0] sb;
   logic [7:0] got;
   int n;
   initial begin
      slave_select_n = 1'b1;
      sck_i = 1'b0;
      mosi_i = 1'b0;
      miso_i = 1'b0;
   end
   // Master: clock idles first, select leads the first edge
   task automatic send(input logic [7:0] mo, output logic [7:0] mi);
      sck_i = cpol;
      #800;
      slave_select_n = 1'b0;
      #800;
      for (int i = 7; i >= 0; i--) begin
         if (!cpha) mosi_i = mo[i];
         #400;
         if (!cpha) mi[i] = miso_o;
         sck_i = ~sck_i;
         if (cpha) mosi_i = mo[i];
         #400;
         if (cpha) mi[i] = miso_o;
         sck_i = ~sck_i;
      end
      #400;
      slave_select_n = 1'b1;
      mosi_i = ~mosi_i;
   endtask
   task automatic load(input logic [7:0] b);
      sb = b;
      n = 0;
      miso_i = cpha ? ~b[7] : b[7];
   endtask
   task automatic glitch();
      slave_select_n = 1'b0;
      #100;
      slave_select_n = 1'b1;
   endtask
   // Slave: capture on one edge, shift on the other, invert MISO after the 16th edge
   always @(sck_o) begin
      if (sck_oe) begin
         n = n + 1;
         if ((n % 2 == 1) != cpha) got = {got[6:0], mosi_o};
         else if (n < 16) miso_i = sb[7 - (n - cpha) / 2];
         if (n == 16) miso_i = ~miso_i;
      end
   end
endmodule // spi_far_end
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the serial configuration and status register.
// Assumes spi_far_end as the far side and the package constants.
`timescale 1ns/1ps
`default_nettype none
module tb;
   import spi_cfg_pkg::*;
   localparam int LIMIT = 20000;
   logic clock = 1'b0, rst_n = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, tx_data = 8'h00;
   logic spi_enable = 1'b0, tx_wr = 1'b0, rx_rd = 1'b0;
   logic cpol = 1'b0, cpha = 1'b0;
   logic [7:0] sfr_rdata, rx_data, r, mi, b, t;
   logic tx_buffer_empty, transfer_complete_flag, slave_select_n, sck_i;
   logic sck_o, sck_oe, mosi_i, mosi_o, mosi_oe, miso_i, miso_o, miso_oe;
   int fails = 0, checked = 0, cycles = 0, nflag = 0, k;
   int exp_q[$];
   spi_cfg_status spi_cfg_status_inst (.clock, .rst_n, .sfr_addr, .sfr_wr,
      .sfr_rd, .sfr_wdata, .sfr_rdata, .spi_enable, .tx_wr, .tx_data,
      .tx_buffer_empty, .rx_rd, .rx_data, .transfer_complete_flag,
      .slave_select_n, .sck_i, .sck_o, .sck_oe, .mosi_i, .mosi_o, .mosi_oe,
      .miso_i, .miso_o, .miso_oe);
   spi_far_end spi_far_end_inst (.cpol, .cpha, .sck_o, .sck_oe, .mosi_o,
      .miso_o, .slave_select_n, .sck_i, .mosi_i, .miso_i);
   always #50 clock = ~clock;
   always @(negedge clock) if (transfer_complete_flag === 1'b1) nflag++;
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fails++;
         final_report();
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clock);
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clock);
      sfr_rd = 1'b0;
      d = sfr_rdata;
   endtask
   task automatic cfg(input logic [7:0] d);
      @(negedge clock);
      spi_enable = 1'b0;
      wr(CFG_ADDR, d);
      spi_enable = 1'b1;
   endtask
   task automatic send_tx(input logic [7:0] d);
      @(negedge clock);
      tx_data = d;
      tx_wr = 1'b1;
      @(negedge clock);
      tx_wr = 1'b0;
   endtask
   // Waits for one completed byte, then compares the receive buffer
   task automatic rx_done();
      for (int i = 0; i < 300 && nflag == k; i++) @(posedge clock);
      repeat (10) @(negedge clock);
      check(8'(nflag - k), 8'h01);
      check(rx_data, 8'(exp_q.pop_front()));
   endtask
   task automatic rx_take();
      rx_rd = 1'b1;
      @(negedge clock);
      rx_rd = 1'b0;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      r = 8'($urandom(3));
      repeat (10) @(negedge clock);
      rst_n = 1'b1;
      rd(CFG_ADDR, r);
      check(r, CFG_RESET);
      wr(CFG_ADDR, 8'h8f);
      wr(8'ha2, 8'h70);
      rd(8'ha2, r);
      check(r, 8'h00);
      rd(CFG_ADDR, r);
      check(r, CFG_RESET);
      for (int m = 0; m < 4; m++) begin
         {cpha, cpol} = 2'(m);
         // Master role: partner acts as slave
         cfg({2'b01, cpha, cpol, 4'h0});
         repeat (4) @(negedge clock);
         check({4'h0, sck_oe, sck_o, mosi_oe, miso_oe},
            {4'h0, 1'b1, cpol, 2'b10});
         b = 8'($urandom);
         t = 8'($urandom);
         spi_far_end_inst.load(b);
         exp_q.push_back(b);
         k = nflag;
         send_tx(t);
         repeat (3) @(negedge clock);
         rd(CFG_ADDR, r);
         check(r, {2'b11, cpha, cpol, 4'b0111});
         rx_done();
         rx_take();
         check(spi_far_end_inst.got, t);
         // Slave role: partner acts as master
         cfg({2'b00, cpha, cpol, 4'h0});
         b = 8'($urandom);
         t = 8'($urandom);
         send_tx(t);
         exp_q.push_back(b);
         k = nflag;
         fork
            spi_far_end_inst.send(b, mi);
            begin
               #3000;
               rd(CFG_ADDR, r);
               check(r, {2'b10, cpha, cpol, 4'b1001});
               check({5'h0, tx_buffer_empty, mosi_oe, miso_oe},
                  8'h05);
            end
         join
         rx_done();
         rd(CFG_ADDR, r);
         check(r, {2'b00, cpha, cpol, 4'b0110});
         rx_take();
         rd(CFG_ADDR, r);
         check({7'h0, r[0]}, 8'h01);
         check(mi, t);
      end
      fork
         spi_far_end_inst.glitch();
         repeat (4) begin
            rd(CFG_ADDR, r);
            check({7'h0, r[3]}, 8'h00);
         end
      join
      final_report();
   end
endmodule // tb
`default_nettype wire
